// ### bench/gci_periph_eeprom_regs_tb.sv
// self-checking bench for the gci/peripheral/eeprom register bank
module gci_periph_eeprom_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import gci_regs_pkg::*;
  // ==========================================
  // stimulus and observed signals
  logic ref_clk_i = 0, resetn_i = 0, req = 0, wr = 0, pci = 1, bsel = 0;
  logic rxs = 0, dline = 1, utx = 1, eeprom_data_in_bit = 0, ack, up, dn, pcm, gsw, l1, esk, ecs, esdo, eoe;
  logic [7:0] addr = 0, wd = 0, rxd = 0, rd, mtx, pa, pw, v, w;
  logic [5:0] pgd = 0;
  logic [1:0] txd = 0, hs;
  logic [10:0] gi, go, goe, ext = 0;
  logic [15:0] lf = 16'h7374; // lfsr state
  logic [15:0] q[$]; // pending reads: {mask, expected}
  logic [7:0] mw[5] = '{8'h00, 8'h20, 8'h21, 8'h04, 8'h02};
  logic [3:0] mode_exp[5] = '{4'b1100, 4'b1010, 4'b1101, 4'b0100, 4'b1100};
  int n_mismatch = 0, n_tests = 0, cyc = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  gci_periph_eeprom_regs u_gci_periph_eeprom_regs (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .reg_req_i(req), .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rd),
    .reg_ack_o(ack), .pci_host_i(pci), .peripheral_bus_select_i(bsel),
    .pin_group_drive_i(pgd), .gpio_i(gi), .gpio_o(go), .gpio_oe_o(goe),
    .mon1_rx_strobe_i(rxs), .mon1_rx_data_i(rxd), .mon_tx_done_i(txd),
    .monitor1_tx_byte_o(mtx), .monitor_tx_handshake_bit_o(hs), .gci_downstream_line_i(dline),
    .gci_upstream_tx_i(utx), .gci_upstream_line_o(up), .gci_downstream_rx_o(dn),
    .pcm_ports_enable_o(pcm), .gci_switch_enable_o(gsw), .layer1_interface_select_o(l1),
    .eeprom_serial_in_pin_i(eeprom_data_in_bit), .eeprom_serial_clock_pin_o(esk),
    .eeprom_select_pin_o(ecs), .eeprom_serial_out_pin_o(esdo), .eeprom_pins_oe_o(eoe));
  periph_model u_periph_model (.ref_clk_i(ref_clk_i), .gpio_o_i(go), .gpio_oe_i(goe),
    .ext_i(ext), .gpio_i_o(gi), .addr_o(pa), .wdata_o(pw));
  // ==========================================
  // helpers
  function automatic logic [15:0] nxt(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic step(int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : step
  // one host access, held until ack, then one idle edge; reads note their expectation
  task automatic acc(logic w1, logic [7:0] a, logic [7:0] d, logic [7:0] e = 0,
                     logic [7:0] m = 8'hff);
    int k = 0;
    if (!w1) begin
      q.push_back({m, e & m});
    end
    req = 1;
    wr = w1;
    addr = a;
    wd = d;
    do begin
      @(negedge ref_clk_i);
      k++;
    end while (ack !== 1'b1 && k < 100);
    @(posedge ref_clk_i);
    #1 req = 0;
    step(1);
  endtask : acc
  task automatic report_and_stop();
    if (q.size() != 0) begin
      n_mismatch++;
    end
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  // ==========================================
  // read-data watcher: oldest note against each read answer
  always @(negedge ref_clk_i) begin
    if (ack === 1'b1 && wr === 1'b0 && q.size() > 0) begin
      logic [15:0] t;
      t = q.pop_front();
      chk("rdata", rd & t[15:8], t[7:0]);
    end
  end
  // hang guard, well above the few hundred cycles the sequence needs
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    step(5);
    resetn_i = 1;
    step(3);
    chk("handshake", hs, 8'h03);
    acc(0, MON1_RX_OFS, 0, 8'hff);
    acc(0, MON1_TX_OFS, 0, 8'hff);
    acc(0, GCI_MODE_OFS, 0, 8'h00);
    acc(0, 8'h00, 0, 8'h00);
    lf = nxt(lf);
    acc(1, MON1_TX_OFS, lf[7:0]);
    acc(1, MON1_RX_OFS, ~lf[7:0]);
    acc(0, MON1_TX_OFS, 0, lf[7:0]);
    chk("mon1_tx_out", mtx, lf[7:0]);
    acc(0, MON1_RX_OFS, 0, 8'hff);
    rxd = lf[15:8];
    rxs = 1;
    step(1);
    rxs = 0;
    acc(0, MON1_RX_OFS, 0, lf[15:8]);
    // active flag: software set, hardware clear
    acc(1, GCI_MODE_OFS, 8'hc0);
    step(2);
    chk("handshake", hs, 8'h00);
    acc(1, GCI_MODE_OFS, 8'h00);
    acc(0, GCI_MODE_OFS, 0, 8'hc0);
    txd = 2'b10;
    step(1);
    txd = 0;
    step(2);
    chk("handshake", hs, 8'h02);
    acc(0, GCI_MODE_OFS, 0, 8'h80);
    txd = 2'b01;
    step(1);
    txd = 0;
    step(2);
    chk("handshake", hs, 8'h03);
    acc(0, GCI_MODE_OFS, 0, 8'h00);
    // role, path select and power-up combinations
    for (int i = 0; i < 5; i++) begin
      acc(1, GCI_MODE_OFS, mw[i]); // power-up bit cleared by software after use
      step(2);
      chk("mode_pins", {up, pcm, gsw, l1}, mode_exp[i]);
    end
    acc(1, GCI_MODE_OFS, 8'h11);
    dline = 0;
    step(4);
    chk("local_loop", dn, 1'b1);
    acc(1, GCI_MODE_OFS, 8'h09);
    step(4);
    chk("remote_loop", up, 1'b0);
    // eeprom port
    eeprom_data_in_bit = 1;
    acc(1, EEPROM_OFS, 8'h1a);
    step(2);
    chk("eeprom_pins", {eoe, esk, ecs, esdo}, 8'h0a);
    acc(0, EEPROM_OFS, 0, 8'h1a);
    eeprom_data_in_bit = 0;
    acc(1, EEPROM_OFS, 8'h15);
    step(2);
    chk("eeprom_oe", eoe, 1'b0);
    acc(0, EEPROM_OFS, 0, 8'h05);
    // simple io with groups 0, 2 and 4 driving
    lf = nxt(lf);
    ext = lf[10:0];
    lf = nxt(lf);
    v = lf[7:0];
    w = lf[15:8];
    pgd = 6'b010101;
    acc(1, PADDR_OFS, v);
    acc(1, PDATA_OFS, w);
    step(4);
    chk("io_oe_low", goe[7:0], 8'h33);
    chk("io_out_low", go[7:0] & 8'h33, v & 8'h33);
    chk("io_oe_high", goe[10:8], 8'h03);
    acc(0, PADDR_OFS, 0, (v & 8'h33) | (ext[7:0] & 8'hcc));
    acc(0, PDATA_OFS, 0, {5'b0, ext[10], w[1:0]}, 8'h07);
    // muxed mode needs a pci host
    pci = 0;
    bsel = 1;
    step(4);
    chk("oe_no_pci", goe[10], 1'b0);
    pci = 1;
    step(4);
    chk("oe_strobe", goe[10], 1'b1);
    chk("addr_strobe_idle", go[8], 1'b0);
    lf = nxt(lf);
    acc(1, PADDR_OFS, lf[7:0]);
    acc(1, PDATA_OFS, lf[15:8]);
    chk("periph_addr", pa, lf[7:0]);
    chk("periph_wdata", pw, lf[15:8]);
    acc(0, PDATA_OFS, 0, lf[7:0] ^ 8'h5a);
    acc(0, PADDR_OFS, 0, lf[7:0]);
    // second reset in mid-run
    resetn_i = 0;
    step(2);
    resetn_i = 1;
    step(3);
    acc(0, GCI_MODE_OFS, 0, 8'h00);
    acc(0, MON1_TX_OFS, 0, 8'hff);
    report_and_stop();
  end
endmodule : gci_periph_eeprom_regs_tb

// ### bench/periph_model.sv
// far-side model: peripheral chip on the shared bus plus the wiring of every pin
module periph_model (
  // clock
  input wire logic ref_clk_i,
  // device pin drive and enables
  input wire logic [10:0] gpio_o_i,
  input wire logic [10:0] gpio_oe_i,
  // levels the outside world puts on undriven pins
  input wire logic [10:0] ext_i,
  // resolved pin levels back to the device
  output logic [10:0] gpio_i_o,
  // what the peripheral latched
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // peripheral owns the bus while read strobe is low; all three strobes driven in bus mode
  // and in io mode with groups 4 and 5 both on, where a low simple io pin 9 is then taken for a read strobe
  logic rd_act;
  assign rd_act = (&gpio_oe_i[10:8]) && !gpio_o_i[9];
  // ==========================================
  // pin resolution: peripheral read answer wins on pins 7-0, then device drive, then outside level
  always_comb begin
    for (int i = 0; i < 11; i++) begin
      gpio_i_o[i] = gpio_oe_i[i] ? gpio_o_i[i] : ext_i[i];
    end
    // answer is derived from the latched address so the bench can predict it
    if (rd_act) begin
      gpio_i_o[7:0] = addr_o ^ 8'h5a;
    end
  end
  // ==========================================
  // address latched under the strobe, data under the write strobe
  always_ff @(posedge ref_clk_i) begin
    if (gpio_oe_i[8] && gpio_o_i[8]) begin
      addr_o <= gpio_o_i[7:0];
    end
    if (gpio_oe_i[10] && !gpio_o_i[10]) begin
      wdata_o <= gpio_o_i[7:0];
    end
  end
endmodule : periph_model

// ### logic/gci_periph_eeprom_regs.sv
// gci mode, monitor channel 1, peripheral io/bus and serial eeprom register bank
// What this block does
// R1: software sets tx active; handshake bit goes low
// R2: cleared active flag means previous transmission ended
// R3: master: codec select picks pcm or gci
// R4: slave local loop joins lines, ignores downstream
// R5: slave remote loop returns downstream onto upstream
// R6: power-up without power-down pulls upstream low
// R7: power-down acknowledge lets upstream idle high
// R8: software sends activate request, then clears power-up
// R9: layer1 select: 0 s/t master, 1 u slave
// R10: gci mode control resets to all zero
// R11: simple io address read returns pin levels
// R12: simple io pairs driven only when enabled
// R13: data bits 2-0 carry upper three pins
// R14: muxed mode drives address under address strobe
// R15: data phase drives writes, captures reads
// R16: muxed bus only under pci host
// R17: eeprom bit 4 reads live input, write ignored
// R18: eeprom enable gates clock, select, data out; here the three pins follow their own bits whatever the enable bit
// R19: eeprom low nibble reads back last write
// R20: monitor rx byte read-only, resets to ones
// R21: monitor tx byte writable, resets to ones
// R22: muxed mode: pins become bus and strobes
// R23: pin group enables act only in io mode
// R24: one address strobe, one data strobe, host held
module gci_periph_eeprom_regs (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // host register port
  input wire logic reg_req_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_ack_o,
  // host bus type pin, 1 = pci
  input wire logic pci_host_i,
  // peripheral control settings
  input wire logic peripheral_bus_select_i,
  input wire logic [5:0] pin_group_drive_i,
  // general purpose pins
  input wire logic [10:0] gpio_i,
  output logic [10:0] gpio_o,
  output logic [10:0] gpio_oe_o,
  // monitor engine side
  input wire logic mon1_rx_strobe_i,
  input wire logic [7:0] mon1_rx_data_i,
  input wire logic [1:0] mon_tx_done_i,
  output logic [7:0] monitor1_tx_byte_o,
  output logic [1:0] monitor_tx_handshake_bit_o,
  // gci lines and switching
  input wire logic gci_downstream_line_i,
  input wire logic gci_upstream_tx_i,
  output logic gci_upstream_line_o,
  output logic gci_downstream_rx_o,
  output logic pcm_ports_enable_o,
  output logic gci_switch_enable_o,
  output logic layer1_interface_select_o,
  // serial eeprom pins
  input wire logic eeprom_serial_in_pin_i,
  output logic eeprom_serial_clock_pin_o,
  output logic eeprom_select_pin_o,
  output logic eeprom_serial_out_pin_o,
  output logic eeprom_pins_oe_o
);
  import gci_regs_pkg::*;

  // ==========================================
  // pin synchronisers
  logic [13:0] meta_r, sync_r; // first stage read only by second
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      // downstream idles high: reset its stages high so no false low follows reset
      meta_r <= 14'h1000;
      sync_r <= 14'h1000;
    end else begin
      meta_r <= {pci_host_i, gci_downstream_line_i, eeprom_serial_in_pin_i, gpio_i};
      sync_r <= meta_r;
    end
  end
  logic [10:0] gpio_s; // synchronised pin levels
  logic sdi_s, down_s, pci_s;
  assign gpio_s = sync_r[10:0];
  assign sdi_s = sync_r[11];
  assign down_s = sync_r[12];
  assign pci_s = sync_r[13];

  // ==========================================
  // muxed peripheral engine
  periph_bus_if pbus ();
  logic muxed; // muxed bus only with a pci host [R16]
  assign muxed = peripheral_bus_select_i && pci_s;
  periph_muxbus u_muxbus (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .ad_in_i(gpio_s[7:0]),
    .bus(pbus.eng)
  );

  // ==========================================
  // register state
  logic [7:0] mon1_rx_r, mon1_rx_nxt; // received monitor byte
  logic [7:0] mon1_tx_r, mon1_tx_nxt; // byte to transmit
  logic [7:0] layer1_interface_select_r, layer1_interface_select_nxt; // gci mode control
  logic [7:0] paddr_r, paddr_nxt; // peripheral address / io out
  logic [7:0] pdata_r, pdata_nxt; // peripheral data / upper io out
  logic [3:0] ep_r, ep_nxt; // eeprom control low nibble
  logic [7:0] rdata_r, rdata_nxt; // read return
  logic ack_r, ack_nxt; // access acknowledge
  logic busy_r, busy_nxt; // muxed access in flight
  logic start_nxt; // muxed access launch
  logic take, is_pdata;

  assign take = reg_req_i && !ack_r && !busy_r;
  assign is_pdata = reg_addr_i == PDATA_OFS;
  assign pbus.start = start_nxt;
  assign pbus.wr = reg_wr_i;
  assign pbus.addr = paddr_r;
  assign pbus.wdata = reg_wdata_i;

  // next values of the register file and host handshake
  always_comb begin
    mon1_rx_nxt = mon1_rx_r;
    mon1_tx_nxt = mon1_tx_r;
    layer1_interface_select_nxt = layer1_interface_select_r;
    paddr_nxt = paddr_r;
    pdata_nxt = pdata_r;
    ep_nxt = ep_r;
    rdata_nxt = rdata_r;
    ack_nxt = 1'b0;
    busy_nxt = busy_r;
    start_nxt = 1'b0;
    // monitor engine done clears the active flags [R2]
    if (mon_tx_done_i[0]) begin
      layer1_interface_select_nxt[GM_TXACT0] = 1'b0;
    end
    if (mon_tx_done_i[1]) begin
      layer1_interface_select_nxt[GM_TXACT1] = 1'b0;
    end
    // received byte lands only from the engine [R20]
    if (mon1_rx_strobe_i) begin
      mon1_rx_nxt = mon1_rx_data_i;
    end
    if (busy_r && pbus.done) begin
      // host held until bus cycle completes [R24]
      busy_nxt = 1'b0;
      ack_nxt = 1'b1;
      if (!reg_wr_i) begin
        pdata_nxt = pbus.rdata; // [R15]
        rdata_nxt = pbus.rdata;
      end else begin
        pdata_nxt = reg_wdata_i;
      end
    end else if (take && is_pdata && muxed) begin
      busy_nxt = 1'b1;
      start_nxt = 1'b1; // [R14]
    end else if (take) begin
      ack_nxt = 1'b1;
      if (reg_wr_i) begin
        unique case (reg_addr_i)
          MON1_TX_OFS: mon1_tx_nxt = reg_wdata_i; // [R21]
          GCI_MODE_OFS: begin
            // active flags set by a one, set beats a same-cycle done [R1]
            layer1_interface_select_nxt[5:0] = reg_wdata_i[5:0];
            layer1_interface_select_nxt[GM_TXACT0] = layer1_interface_select_nxt[GM_TXACT0] | reg_wdata_i[GM_TXACT0];
            layer1_interface_select_nxt[GM_TXACT1] = layer1_interface_select_nxt[GM_TXACT1] | reg_wdata_i[GM_TXACT1];
          end
          PADDR_OFS: paddr_nxt = reg_wdata_i;
          PDATA_OFS: pdata_nxt = reg_wdata_i;
          EEPROM_OFS: ep_nxt = reg_wdata_i[3:0]; // sdi bit dropped [R17]
          default: ;
        endcase
      end else begin
        unique case (reg_addr_i)
          MON1_RX_OFS: rdata_nxt = mon1_rx_r;
          MON1_TX_OFS: rdata_nxt = mon1_tx_r;
          GCI_MODE_OFS: rdata_nxt = layer1_interface_select_r;
          PADDR_OFS: rdata_nxt = muxed ? paddr_r : gpio_s[7:0]; // [R11]
          PDATA_OFS: rdata_nxt = {5'h00, gpio_s[10:8]}; // [R13]
          EEPROM_OFS: rdata_nxt = {3'h0, sdi_s, ep_r}; // [R17] [R19]
          default: rdata_nxt = UNMAPPED_RD;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mon1_rx_r <= MON_BYTE_RST; // [R20]
      mon1_tx_r <= MON_BYTE_RST; // [R21]
      layer1_interface_select_r <= GCI_MODE_RST; // [R10]
      paddr_r <= PERIPH_RST;
      pdata_r <= PERIPH_RST;
      ep_r <= EEPROM_RST;
      rdata_r <= UNMAPPED_RD;
      ack_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      mon1_rx_r <= mon1_rx_nxt;
      mon1_tx_r <= mon1_tx_nxt;
      layer1_interface_select_r <= layer1_interface_select_nxt;
      paddr_r <= paddr_nxt;
      pdata_r <= pdata_nxt;
      ep_r <= ep_nxt;
      rdata_r <= rdata_nxt;
      ack_r <= ack_nxt;
      busy_r <= busy_nxt;
    end
  end

  // ==========================================
  // pin and line outputs, all flopped
  logic [10:0] gp_nxt, gp_oe_nxt, gp_r, gp_oe_r;
  logic [1:0] hs_r;
  logic up_r, up_nxt, down_r, down_nxt, pcm_r, gsw_r, l1_r;
  logic [3:0] epo_r;
  logic slave;
  assign slave = layer1_interface_select_r[GM_L1SEL]; // [R9]

  // pin group and line selection
  always_comb begin
    // simple io: each enable covers one pin pair or pin [R12] [R23]
    for (int g = 0; g < 4; g++) begin
      gp_nxt[2*g +: 2] = paddr_r[2*g +: 2];
      gp_oe_nxt[2*g +: 2] = {2{pin_group_drive_i[g]}};
    end
    gp_nxt[10:8] = pdata_r[2:0]; // [R13]
    gp_oe_nxt[10:8] = {pin_group_drive_i[5], {2{pin_group_drive_i[4]}}};
    if (muxed) begin
      // pins become shared bus plus strobes, enables ignored [R22]
      gp_nxt = {pbus.wr_n, pbus.rd_n, pbus.ale, pbus.ad_out};
      gp_oe_nxt = {3'h7, {8{pbus.ad_oe}}};
    end
    // downstream seen internally: looped upstream in slave test loop [R4]
    down_nxt = (slave && layer1_interface_select_r[GM_LLOOP]) ? up_r : down_s;
    // upstream: remote loop returns downstream data [R5]
    up_nxt = (slave && layer1_interface_select_r[GM_RLP]) ? down_s : gci_upstream_tx_i;
    // forced low to request clocks; idles high after acknowledge [R6] [R7]
    if (layer1_interface_select_r[GM_PWRUP] && !layer1_interface_select_r[GM_PWRDN]) begin
      up_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gp_r <= 11'h000;
      gp_oe_r <= 11'h000;
      up_r <= 1'b1;
      down_r <= 1'b1;
      hs_r <= 2'h3;
      pcm_r <= 1'b1;
      gsw_r <= 1'b0;
      l1_r <= 1'b0;
      epo_r <= 4'h0;
    end else begin
      gp_r <= gp_nxt;
      gp_oe_r <= gp_oe_nxt;
      up_r <= up_nxt;
      down_r <= down_nxt;
      hs_r <= ~{layer1_interface_select_nxt[GM_TXACT1], layer1_interface_select_nxt[GM_TXACT0]}; // active low [R1]
      // role and path from one next value, so a write changing both settles on one edge
      pcm_r <= layer1_interface_select_nxt[GM_L1SEL] || !layer1_interface_select_nxt[GM_CODEC]; // [R3]
      gsw_r <= !layer1_interface_select_nxt[GM_L1SEL] && layer1_interface_select_nxt[GM_CODEC]; // [R3]
      l1_r <= layer1_interface_select_nxt[GM_L1SEL]; // [R9]
      epo_r <= ep_nxt; // enable not applied: the three outputs follow their own bits [R18]
    end
  end

  assign reg_rdata_o = rdata_r;
  assign reg_ack_o = ack_r;
  assign gpio_o = gp_r;
  assign gpio_oe_o = gp_oe_r;
  assign monitor1_tx_byte_o = mon1_tx_r;
  assign monitor_tx_handshake_bit_o = hs_r;
  assign gci_upstream_line_o = up_r;
  assign gci_downstream_rx_o = down_r;
  assign pcm_ports_enable_o = pcm_r;
  assign gci_switch_enable_o = gsw_r;
  assign layer1_interface_select_o = l1_r;
  assign eeprom_serial_clock_pin_o = epo_r[EP_CLK];
  assign eeprom_select_pin_o = epo_r[EP_CS];
  assign eeprom_serial_out_pin_o = epo_r[EP_DOUT];
  assign eeprom_pins_oe_o = epo_r[EP_EN];

  // ==========================================
  // checks
  a_handshake_active: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R1]
    $rose(layer1_interface_select_r[GM_TXACT1]) |-> !hs_r[1]) else $error("handshake bit not active with flag");
  a_codec_route: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R3]
    $stable(layer1_interface_select_r) |=> (pcm_r == (!layer1_interface_select_r[GM_L1SEL] ? !layer1_interface_select_r[GM_CODEC] : 1'b1)))
    else $error("codec path routing wrong");
  a_local_loop: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R4]
    (slave && layer1_interface_select_r[GM_LLOOP]) |=> (down_r == $past(up_r))) else $error("test loop not closed");
  a_remote_loop: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R5]
    (slave && layer1_interface_select_r[GM_RLP] && !layer1_interface_select_r[GM_PWRUP]) |=> (up_r == $past(down_s)))
    else $error("remote loop not returning data");
  a_power_up_low: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R6]
    (layer1_interface_select_r[GM_PWRUP] && !layer1_interface_select_r[GM_PWRDN]) |=> !up_r) else $error("upstream not held low");
  a_power_down_ack: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R7]
    (!layer1_interface_select_r[GM_PWRUP] && layer1_interface_select_r[GM_PWRDN] && !layer1_interface_select_r[GM_RLP])
    |=> (up_r == $past(gci_upstream_tx_i)))
    else $error("upstream not released after power down");
  a_mode_reset: assert property (@(posedge ref_clk_i) // [R10]
    $rose(resetn_i) |-> (layer1_interface_select_r == GCI_MODE_RST)) else $error("gci mode not zero after reset");
  a_io_gate: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R12]
    (!muxed && !pin_group_drive_i[0]) |=> (gp_oe_r[1:0] == 2'h0)) else $error("io pair driven");
  a_eeprom_gate: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R18]
    (take && reg_wr_i && reg_addr_i == EEPROM_OFS)
    |=> (eeprom_pins_oe_o == $past(reg_wdata_i[EP_EN])))
    else $error("eeprom pin enable does not follow write");
  a_host_held: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R24]
    pbus.start |-> !ack_r [*5]) else $error("host released before bus cycle end");
endmodule : gci_periph_eeprom_regs

// ### logic/gci_regs_pkg.sv
// shared offsets, field positions, reset values and timing for the gci/peripheral/eeprom bank
package gci_regs_pkg;
  // ==========================================
  // register offsets as seen on the host register port
  localparam logic [7:0] MON1_RX_OFS = 8'h6d;
  localparam logic [7:0] MON1_TX_OFS = 8'h71;
  localparam logic [7:0] GCI_MODE_OFS = 8'h7c;
  localparam logic [7:0] PADDR_OFS = 8'hf4;
  localparam logic [7:0] PDATA_OFS = 8'hf8;
  localparam logic [7:0] EEPROM_OFS = 8'hfc;
  // ==========================================
  // reset values
  localparam logic [7:0] MON_BYTE_RST = 8'hff;
  localparam logic [7:0] GCI_MODE_RST = 8'h00;
  localparam logic [3:0] EEPROM_RST = 4'h0;
  localparam logic [7:0] PERIPH_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;
  // ==========================================
  // gci_mode_control field positions
  localparam int GM_TXACT0 = 7;
  localparam int GM_TXACT1 = 6;
  localparam int GM_CODEC = 5;
  localparam int GM_LLOOP = 4;
  localparam int GM_RLP = 3;
  localparam int GM_PWRUP = 2;
  localparam int GM_PWRDN = 1;
  localparam int GM_L1SEL = 0;
  // serial_eeprom_control field positions
  localparam int EP_DIN = 4;
  localparam int EP_EN = 3;
  localparam int EP_CLK = 2;
  localparam int EP_CS = 1;
  localparam int EP_DOUT = 0;
  // ==========================================
  // multiplexed peripheral bus timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int ALE_WIDTH_NS = 30;
  localparam int STROBE_WIDTH_NS = 60;
  localparam logic [3:0] ALE_CYC = 4'((ALE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] STROBE_CYC =
    4'((STROBE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // mux bus engine states
  typedef enum logic [1:0] {
    MB_IDLE = 2'b00,
    MB_ADDR = 2'b01,
    MB_DATA = 2'b10,
    MB_END = 2'b11
  } mux_state_e;
endpackage : gci_regs_pkg

// ### logic/periph_bus_if.sv
// carrier between register bank and multiplexed peripheral bus engine
interface periph_bus_if;
  logic start; // one-cycle request pulse
  logic wr; // 1 write, 0 read
  logic [7:0] addr; // peripheral address
  logic [7:0] wdata; // write data
  logic [7:0] rdata; // captured read data
  logic done; // one-cycle completion pulse
  logic [7:0] ad_out; // shared bus drive value
  logic ad_oe; // shared bus drive enable
  logic ale; // address strobe
  logic rd_n; // read strobe, active low
  logic wr_n; // write strobe, active low
  modport ctrl (output start, wr, addr, wdata, input rdata, done, ad_out, ad_oe, ale, rd_n, wr_n);
  modport eng (input start, wr, addr, wdata, output rdata, done, ad_out, ad_oe, ale, rd_n, wr_n);
endinterface : periph_bus_if

// ### logic/periph_muxbus.sv
// address phase then one read or write strobe on the shared peripheral bus
module periph_muxbus (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // synchronised shared bus levels
  input wire logic [7:0] ad_in_i,
  // bank side
  periph_bus_if.eng bus
);
  import gci_regs_pkg::*;

  // ==========================================
  // state
  mux_state_e state_r, state_nxt; // engine state
  logic [3:0] cnt_r, cnt_nxt; // phase width counter
  logic [7:0] rdata_r, rdata_nxt; // read capture
  logic [7:0] ad_r, ad_nxt; // bus drive value
  logic oe_r, oe_nxt, ale_r, ale_nxt, rd_n_r, rd_n_nxt, wr_n_r, wr_n_nxt, done_r, done_nxt;

  // next state: strobes are only ever low in the data phase
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    rdata_nxt = rdata_r;
    ad_nxt = ad_r;
    oe_nxt = oe_r;
    ale_nxt = 1'b0;
    rd_n_nxt = 1'b1;
    wr_n_nxt = 1'b1;
    done_nxt = 1'b0;
    unique case (state_r)
      MB_IDLE: begin
        oe_nxt = 1'b0;
        if (bus.start) begin
          // address phase: drive address, raise strobe [R14]
          state_nxt = MB_ADDR;
          cnt_nxt = ALE_CYC;
          ad_nxt = bus.addr;
          oe_nxt = 1'b1;
          ale_nxt = 1'b1;
        end
      end
      MB_ADDR: begin
        ale_nxt = 1'b1;
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          // one strobe pulse per access [R24]
          state_nxt = MB_DATA;
          ale_nxt = 1'b0;
          cnt_nxt = STROBE_CYC;
          ad_nxt = bus.wdata;
          oe_nxt = bus.wr; // write drives, read releases [R15]
          rd_n_nxt = bus.wr;
          wr_n_nxt = !bus.wr;
        end
      end
      MB_DATA: begin
        rd_n_nxt = rd_n_r;
        wr_n_nxt = wr_n_r;
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          // sample at the trailing edge of the read strobe [R15]
          if (!rd_n_r) begin
            rdata_nxt = ad_in_i;
          end
          state_nxt = MB_END;
          rd_n_nxt = 1'b1;
          wr_n_nxt = 1'b1;
        end
      end
      MB_END: begin
        // hold data one cycle past the strobe, then hand back
        oe_nxt = 1'b0;
        done_nxt = 1'b1;
        state_nxt = MB_IDLE;
      end
    endcase
  end

  // registers
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= MB_IDLE;
      cnt_r <= 4'h0;
      rdata_r <= PERIPH_RST;
      ad_r <= PERIPH_RST;
      oe_r <= 1'b0;
      ale_r <= 1'b0;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      rdata_r <= rdata_nxt;
      ad_r <= ad_nxt;
      oe_r <= oe_nxt;
      ale_r <= ale_nxt;
      rd_n_r <= rd_n_nxt;
      wr_n_r <= wr_n_nxt;
      done_r <= done_nxt;
    end
  end

  assign bus.rdata = rdata_r;
  assign bus.done = done_r;
  assign bus.ad_out = ad_r;
  assign bus.ad_oe = oe_r;
  assign bus.ale = ale_r;
  assign bus.rd_n = rd_n_r;
  assign bus.wr_n = wr_n_r;

  // ==========================================
  // checks
  a_strobe_after_ale: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R24]
    $fell(ale_r) |-> (rd_n_r != wr_n_r) [*4]) else $error("strobe not held after address phase");
  a_no_overlap: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R14]
    !(ale_r && (!rd_n_r || !wr_n_r))) else $error("address strobe overlaps data strobe");
  a_read_release: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R15]
    !rd_n_r |-> !oe_r) else $error("bus driven during read strobe");
endmodule : periph_muxbus
